// >>> src/cise_core.sv
// execution core for a subset of a 14-bit instruction set
// assumes the register file answers reads combinationally in the same cycle
// and that the stack delivers the top entry combinationally
// and that a read in the cycle of a pending file write returns the data
// being written; the core keeps no forwarding path of its own
// irq_take is a level that must stay up until stack_push answers it;
// it is not looked at in the flush cycle of a return
// a return's flush cycle and an interrupt entry cycle are the only bubbles; other words go one per edge
`timescale 1ns/100ps
`default_nettype none
module cise_core (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // instruction fetch
   input wire logic insn_valid,
   input wire logic [13:0] insn,
   output logic insn_ready,
   output logic flush,
   // register file
   output logic [6:0] rf_addr,
   input wire logic [7:0] rf_rdata,
   output logic rf_we,
   output logic [7:0] rf_wdata,
   // return stack
   input wire logic [12:0] stack_top_entry,
   output logic stack_pop,
   output logic pc_load,
   output logic [12:0] pc_value,
   // interrupt entry and control
   input wire logic irq_take,
   input wire logic [12:0] irq_return_pc,
   output logic stack_push,
   output logic [12:0] stack_push_value,
   output logic [7:0] irq_control_register,
   output logic global_irq_enable,
   // architectural state
   output logic [7:0] w_reg,
   output logic [7:0] status_reg
);
   // ==========================================================
   // decoder
   cise_decode_if dif ();
   cise_decoder u_dec (
      .insn (insn),
      .d (dif.dec)
   );

   // ==========================================================
   // state, and the registered pulses and data that leave the core
   cise_pkg::cise_state_e state_ff, nxt_state_ff;
   logic [7:0] w_ff, nxt_w_ff;
   logic [7:0] status_ff, nxt_status_ff;
   logic [7:0] intctl_ff, nxt_intctl_ff;
   logic [12:0] pc_ff, nxt_pc_ff;
   logic pcld_ff, nxt_pcld_ff;
   logic pop_ff, nxt_pop_ff;
   logic rfwe_ff, nxt_rfwe_ff;
   logic [7:0] rfwd_ff, nxt_rfwd_ff;
   logic push_ff, nxt_push_ff;
   logic [12:0] pushv_ff, nxt_pushv_ff;

   // ==========================================================
   // zero flag update shared by several ops
   function automatic logic [7:0] set_zero(input logic [7:0] st, input logic [7:0] res);
      logic [7:0] o;
      o = st;
      o[cise_pkg::STAT_Z_BIT] = (res == 8'h00);
      return o;
   endfunction : set_zero

   // ==========================================================
   // execution next state
   always_comb begin
      logic [7:0] res;
      res = 8'h00;
      // defaults hold all state and drop every one-cycle pulse
      nxt_state_ff = state_ff;
      nxt_w_ff = w_ff;
      nxt_status_ff = status_ff;
      nxt_intctl_ff = intctl_ff;
      nxt_pc_ff = pc_ff;
      nxt_pcld_ff = 1'b0;
      nxt_pop_ff = 1'b0;
      nxt_rfwe_ff = 1'b0;
      nxt_rfwd_ff = rfwd_ff;
      nxt_push_ff = 1'b0;
      nxt_pushv_ff = pushv_ff;
      case (state_ff)
         cise_pkg::CISE_ST_FLUSH: begin
            // second cycle of a return: fetched word is discarded
            // an interrupt raised now is seen one cycle later
            nxt_state_ff = cise_pkg::CISE_ST_EXEC;
         end
         default: begin
            if (irq_take) begin
               // only the return address is saved, W and status stay live
               nxt_push_ff = 1'b1;
               nxt_pushv_ff = irq_return_pc;
            end else if (insn_valid) begin
               // one result path; unknown words leave all state alone
               case (dif.op)
                  cise_pkg::CISE_OP_DEC: begin
                     res = rf_rdata - 8'h01;
                     nxt_status_ff = set_zero(status_ff, res);
                  end
                  cise_pkg::CISE_OP_ROTL: begin
                     res = {rf_rdata[6:0], status_ff[cise_pkg::STAT_C_BIT]};
                     nxt_status_ff[cise_pkg::STAT_C_BIT] = rf_rdata[7];
                  end
                  cise_pkg::CISE_OP_XORF: begin
                     res = w_ff ^ rf_rdata;
                     nxt_status_ff = set_zero(status_ff, res);
                  end
                  cise_pkg::CISE_OP_XORL: begin
                     nxt_w_ff = w_ff ^ dif.literal;
                     nxt_status_ff = set_zero(status_ff, w_ff ^ dif.literal);
                  end
                  cise_pkg::CISE_OP_RETI: begin
                     nxt_intctl_ff[cise_pkg::IRQ_EN_BIT] = 1'b1;
                  end
                  cise_pkg::CISE_OP_RETL: begin
                     nxt_w_ff = dif.literal;
                  end
                  default: begin
                     res = 8'h00;
                  end
               endcase
               // file-register ops pick destination from d
               if (dif.op == cise_pkg::CISE_OP_DEC || dif.op == cise_pkg::CISE_OP_ROTL
                   || dif.op == cise_pkg::CISE_OP_XORF) begin
                  if (dif.dest_reg) begin
                     nxt_rfwe_ff = 1'b1;
                     nxt_rfwd_ff = res;
                  end else begin
                     nxt_w_ff = res;
                  end
               end
               // all three returns: pop, load pc, then a flush cycle
               if (dif.op == cise_pkg::CISE_OP_RETI || dif.op == cise_pkg::CISE_OP_RET
                   || dif.op == cise_pkg::CISE_OP_RETL) begin
                  nxt_pop_ff = 1'b1;
                  nxt_pcld_ff = 1'b1;
                  // the popped entry is captured now; the stack moves an edge later, at the end of the flush cycle
                  nxt_pc_ff = stack_top_entry;
                  nxt_state_ff = cise_pkg::CISE_ST_FLUSH;
               end
            end
         end
      endcase
   end

   // ==========================================================
   // state registers
   // pulses clear on reset so nothing stray reaches the stack or the file
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= cise_pkg::CISE_ST_EXEC;
         w_ff <= cise_pkg::W_RESET;
         status_ff <= cise_pkg::STATUS_RESET;
         intctl_ff <= cise_pkg::INTCTL_RESET;
         pc_ff <= '0;
         pcld_ff <= 1'b0;
         pop_ff <= 1'b0;
         rfwe_ff <= 1'b0;
         rfwd_ff <= 8'h00;
         push_ff <= 1'b0;
         pushv_ff <= '0;
      end else begin
         state_ff <= nxt_state_ff;
         w_ff <= nxt_w_ff;
         status_ff <= nxt_status_ff;
         intctl_ff <= nxt_intctl_ff;
         pc_ff <= nxt_pc_ff;
         pcld_ff <= nxt_pcld_ff;
         pop_ff <= nxt_pop_ff;
         rfwe_ff <= nxt_rfwe_ff;
         rfwd_ff <= nxt_rfwd_ff;
         push_ff <= nxt_push_ff;
         pushv_ff <= nxt_pushv_ff;
      end
   end

   // ==========================================================
   // outputs; ready drops in the flush cycle so the stale word is dropped
   assign insn_ready = (state_ff == cise_pkg::CISE_ST_EXEC) && !irq_take;
   assign flush = (state_ff == cise_pkg::CISE_ST_FLUSH);

   // register file; the address follows the word now on the bus, not the one
   // being written back, so the file must hold the taken word's address
   assign rf_addr = dif.faddr;
   assign rf_we = rfwe_ff;
   assign rf_wdata = rfwd_ff;

   // stack and program counter pulses
   assign stack_pop = pop_ff;
   assign pc_load = pcld_ff;
   assign pc_value = pc_ff;
   assign stack_push = push_ff;
   assign stack_push_value = pushv_ff;

   // architectural state
   assign irq_control_register = intctl_ff;
   assign global_irq_enable = intctl_ff[cise_pkg::IRQ_EN_BIT];
   assign w_reg = w_ff;
   assign status_reg = status_ff;
endmodule : cise_core
`default_nettype wire

// >>> src/cise_decode_if.sv
// interface carrying decoded instruction fields between decoder and core
// assumes one decoder and one consumer on the same clock
`timescale 1ns/100ps
`default_nettype none
interface cise_decode_if;
   cise_pkg::cise_op_e op;
   logic dest_reg;
   logic [6:0] faddr;
   logic [7:0] literal;
   modport dec (output op, output dest_reg, output faddr, output literal);
   modport core (input op, input dest_reg, input faddr, input literal);
endinterface : cise_decode_if
`default_nettype wire

// >>> src/cise_decoder.sv
// combinational decoder for the supported instruction subset
// assumes the instruction word is stable while insn_valid is high
`timescale 1ns/100ps
`default_nettype none
module cise_decoder (
   // instruction word
   input wire logic [13:0] insn,
   // decoded fields
   cise_decode_if.dec d
);
   // ==========================================================
   // decode, exact patterns first, unknown words do nothing
   always_comb begin
      d.dest_reg = insn[cise_pkg::DEST_BIT];
      d.faddr = insn[6:0];
      d.literal = insn[7:0];
      if (insn == cise_pkg::OPC_IRQ_RETURN) begin
         d.op = cise_pkg::CISE_OP_RETI;
      end else if (insn == cise_pkg::OPC_SUB_RETURN) begin
         d.op = cise_pkg::CISE_OP_RET;
      end else if (insn[13:8] == cise_pkg::OPC_DECREMENT) begin
         d.op = cise_pkg::CISE_OP_DEC;
      end else if (insn[13:8] == cise_pkg::OPC_ROTATE_LEFT) begin
         d.op = cise_pkg::CISE_OP_ROTL;
      end else if (insn[13:8] == cise_pkg::OPC_XOR_REG) begin
         d.op = cise_pkg::CISE_OP_XORF;
      end else if (insn[13:8] == cise_pkg::OPC_XOR_LIT) begin
         d.op = cise_pkg::CISE_OP_XORL;
      end else if (insn[13:10] == cise_pkg::OPC_RET_LIT) begin
         d.op = cise_pkg::CISE_OP_RETL; // bits 9:8 ignored
      end else begin
         d.op = cise_pkg::CISE_OP_NONE;
      end
   end
endmodule : cise_decoder
`default_nettype wire

// >>> src/cise_pkg.sv
// package for the instruction subset execution block
// assumes 14-bit instruction words and an 8-bit data path
package cise_pkg;
   // ==========================================================
   // widths
   localparam int INSN_W = 14;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int PC_W = 13;
   // ==========================================================
   // opcode patterns
   localparam logic [13:0] OPC_IRQ_RETURN = 14'h0009;
   localparam logic [13:0] OPC_SUB_RETURN = 14'h0008;
   localparam logic [5:0] OPC_DECREMENT = 6'h03;
   localparam logic [5:0] OPC_ROTATE_LEFT = 6'h0D;
   localparam logic [5:0] OPC_XOR_REG = 6'h06;
   localparam logic [5:0] OPC_XOR_LIT = 6'h3A;
   localparam logic [3:0] OPC_RET_LIT = 4'hD;
   // ==========================================================
   // field positions and reset values
   localparam int DEST_BIT = 7;
   localparam int IRQ_EN_BIT = 7;
   localparam logic [7:0] W_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] INTCTL_RESET = 8'h00;
   localparam int STAT_C_BIT = 0;
   localparam int STAT_Z_BIT = 2;
   // ==========================================================
   // decoded operation
   typedef enum logic [7:0] {
      CISE_OP_NONE = 8'h01,
      CISE_OP_DEC = 8'h02,
      CISE_OP_ROTL = 8'h04,
      CISE_OP_XORF = 8'h08,
      CISE_OP_XORL = 8'h10,
      CISE_OP_RETI = 8'h20,
      CISE_OP_RET = 8'h40,
      CISE_OP_RETL = 8'h80
   } cise_op_e;
   // execution state
   typedef enum logic [1:0] {
      CISE_ST_EXEC = 2'h1,
      CISE_ST_FLUSH = 2'h2
   } cise_state_e;
endpackage : cise_pkg

// >>> testbench/cise_checker.sv
// assertions on the ports of the instruction subset core
// assumes it is bound to cise_core and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module cise_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // fetch
   input wire logic insn_valid,
   input wire logic [13:0] insn,
   input wire logic insn_ready,
   input wire logic flush,
   // register file
   input wire logic [7:0] rf_rdata,
   input wire logic rf_we,
   input wire logic [7:0] rf_wdata,
   // stack and interrupt
   input wire logic [12:0] stack_top_entry,
   input wire logic stack_pop,
   input wire logic pc_load,
   input wire logic [12:0] pc_value,
   input wire logic irq_take,
   input wire logic [12:0] irq_return_pc,
   input wire logic stack_push,
   input wire logic [12:0] stack_push_value,
   input wire logic global_irq_enable,
   // state
   input wire logic [7:0] w_reg,
   input wire logic [7:0] status_reg
);
   // ==========================================================
   // decode of the word taken at this edge
   logic take, is_ret, is_retl;
   assign take = insn_valid && insn_ready;
   assign is_retl = insn[13:10] == cise_pkg::OPC_RET_LIT;
   assign is_ret = is_retl || insn == cise_pkg::OPC_IRQ_RETURN
      || insn == cise_pkg::OPC_SUB_RETURN;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // a return pops once and refuses the next word for one cycle
   sequence s_pop;
      stack_pop && pc_load && flush && !insn_ready;
   endsequence
   a_ret_two_cyc: assert property (take && is_ret |=> s_pop ##1 !flush)
      else $error("return not two cycles");
   a_ret_pc_top: assert property (take && is_ret |=> pc_value == $past(stack_top_entry))
      else $error("pc not loaded from stack top");
   a_ret_flags_kept: assert property (take && is_ret |=> $stable(status_reg))
      else $error("return changed status");
   a_reti_sets_irqen: assert property (take && insn == cise_pkg::OPC_IRQ_RETURN
      |=> global_irq_enable)
      else $error("irq return left enable low");
   a_retl_loads_w: assert property (take && is_retl |=> w_reg == $past(insn[7:0]))
      else $error("literal not in w");
   a_xorl_result: assert property (take && insn[13:8] == cise_pkg::OPC_XOR_LIT
      |=> w_reg == ($past(w_reg) ^ $past(insn[7:0])) && status_reg[2] == (w_reg == 8'h00))
      else $error("xor literal wrong");
   a_dec_writeback: assert property (take
      && insn[13:7] == {cise_pkg::OPC_DECREMENT, 1'h1}
      |=> rf_we && rf_wdata == $past(rf_rdata) - 8'h01 && $stable(status_reg[0]))
      else $error("decrement write wrong");
   a_rotl_carry_out: assert property (take && insn[13:8] == cise_pkg::OPC_ROTATE_LEFT
      |=> status_reg[0] == $past(rf_rdata[7]))
      else $error("rotate carry wrong");
   a_irq_push_pc: assert property (irq_take && !flush
      |=> stack_push && stack_push_value == $past(irq_return_pc))
      else $error("entry did not push pc");
   a_single_no_flush: assert property (take && !is_ret |=> !flush)
      else $error("single op flushed");
endmodule : cise_checker
bind cise_core cise_checker cise_checker_inst (.*);
`default_nettype wire

// >>> testbench/cise_core_tb.sv
// self-checking bench for the instruction subset core
// assumes the partner model preloads mem[i] = i*37+5
`timescale 1ns/100ps
`default_nettype none
module cise_core_tb;
   typedef struct {
      logic [13:0] op;
      logic [7:0] w;
      logic z, c, we;
      logic [7:0] wd;
   } cise_row_s;
   logic clk = 1'h0, rst = 1'h1, insn_valid = 1'h0, irq_take = 1'h0;
   logic [13:0] insn = 14'h0000;
   logic [12:0] irq_return_pc = 13'h0000;
   logic insn_ready, flush, rf_we, stack_pop, pc_load, stack_push, global_irq_enable;
   logic [6:0] rf_addr;
   logic [7:0] rf_rdata, rf_wdata, irq_control_register, w_reg, status_reg;
   logic [12:0] stack_top_entry, pc_value, stack_push_value;
   int n_errors = 0, num_checks = 0;
   wire logic take = insn_valid && insn_ready;
   // back-to-back single-cycle ops, chained through w and carry;
   // the last pair reads a register written by the op just before
   cise_row_s rows [12] = '{
      '{14'h3AA5, 8'hA5, 1'h0, 1'h0, 1'h0, 8'h00}, '{14'h0610, 8'hF0, 1'h0, 1'h0, 1'h0, 8'h00},
      '{14'h3AF0, 8'h00, 1'h1, 1'h0, 1'h0, 8'h00}, '{14'h0301, 8'h29, 1'h0, 1'h0, 1'h0, 8'h00},
      '{14'h0390, 8'h29, 1'h0, 1'h0, 1'h1, 8'h54}, '{14'h0D04, 8'h32, 1'h0, 1'h1, 1'h0, 8'h00},
      '{14'h0D84, 8'h32, 1'h0, 1'h1, 1'h1, 8'h33}, '{14'h0681, 8'h32, 1'h0, 1'h1, 1'h1, 8'h18},
      '{14'h0610, 8'h66, 1'h0, 1'h1, 1'h0, 8'h00}, '{14'h034C, 8'h00, 1'h1, 1'h1, 1'h0, 8'h00},
      '{14'h03CC, 8'h00, 1'h1, 1'h1, 1'h1, 8'h00}, '{14'h064C, 8'h00, 1'h1, 1'h1, 1'h0, 8'h00}};
   cise_core cise_core_inst (.clk, .rst, .insn_valid, .insn, .insn_ready, .flush, .rf_addr,
      .rf_rdata, .rf_we, .rf_wdata, .stack_top_entry, .stack_pop, .pc_load, .pc_value,
      .irq_take, .irq_return_pc, .stack_push, .stack_push_value, .irq_control_register,
      .global_irq_enable, .w_reg, .status_reg);
   cise_partner cise_partner_inst (.clk, .take, .rf_addr, .rf_rdata, .rf_we, .rf_wdata,
      .stack_push, .stack_push_value, .stack_pop, .stack_top_entry);
   // 200 MHz clock
   always #2.5 clk = ~clk;
   task chk(input logic [15:0] s, input logic [15:0] e);
      num_checks++;
      if (s !== e) begin
         n_errors++;
         $display("BAD t=%0t seen %h exp %h", $time, s, e);
      end
   endtask : chk
   task chk_row(input cise_row_s r);
      chk(w_reg, r.w);
      chk(status_reg[2], r.z);
      chk(status_reg[0], r.c);
      chk(rf_we, r.we);
      if (r.we) chk(rf_wdata, r.wd);
   endtask : chk_row
   // interrupt entry pushes pc, then a return pops it; junk offered in flush
   task ret_t(input logic [13:0] op, input logic [12:0] pc);
      logic [7:0] w0, s0;
      w0 = w_reg;
      @(posedge clk);
      irq_take <= 1'h1;
      irq_return_pc <= pc;
      @(posedge clk);
      irq_take <= 1'h0;
      #1;
      chk(stack_push, 1'h1);
      chk(stack_push_value, pc);
      chk(w_reg, w0);
      s0 = status_reg;
      @(posedge clk);
      insn <= op;
      insn_valid <= 1'h1;
      @(posedge clk);
      insn <= 14'h3AFF;
      #1;
      chk({stack_pop, pc_load, flush, insn_ready}, 4'hE);
      chk(pc_value, pc);
      chk(status_reg, s0);
      if (op == cise_pkg::OPC_IRQ_RETURN) chk(global_irq_enable, 1'h1);
      @(posedge clk);
      insn_valid <= 1'h0;
      #1;
      chk(flush, 1'h0);
      chk(w_reg, (op[13:12] == 2'h3) ? 8'hC3 : w0);
      $display("return test %h done", op);
   endtask : ret_t
   task end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_of_test
   // main sequence: reset values, row table, then the returns
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      #1;
      chk({w_reg, status_reg}, 16'h0000);
      chk({irq_control_register, flush}, 9'h000);
      $display("reset test done");
      foreach (rows[i]) begin
         @(posedge clk);
         insn_valid <= 1'h1;
         insn <= rows[i].op;
         #1;
         if (i > 0) chk_row(rows[i - 1]);
      end
      @(posedge clk);
      insn_valid <= 1'h0;
      #1;
      chk_row(rows[11]);
      $display("row tests done");
      ret_t(14'h0009, 13'h0ABC);
      ret_t(14'h0008, 13'h1555);
      ret_t(14'h37C3, 13'h0001);
      // reset in mid-run clears w, flags and enable; a word offered at release is taken
      @(posedge clk);
      rst <= 1'h1;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      insn <= 14'h3A5A;
      insn_valid <= 1'h1;
      #1;
      chk({w_reg, status_reg}, 16'h0000);
      chk({irq_control_register, flush}, 9'h000);
      @(posedge clk);
      insn_valid <= 1'h0;
      #1;
      chk(w_reg, 8'h5A);
      chk(status_reg[2], 1'h0);
      $display("mid-run reset test done");
      end_of_test();
   end
   // watchdog: the run needs under 100 cycles
   initial begin
      repeat (300) @(posedge clk);
      n_errors++;
      end_of_test();
   end
endmodule : cise_core_tb
`default_nettype wire

// >>> testbench/cise_partner.sv
// register file and return stack standing beside the core
// assumes writes land on the edge after the core's write pulse
`timescale 1ns/100ps
`default_nettype none
module cise_partner (
   // clock and take strobe
   input wire logic clk,
   input wire logic take,
   // register file
   input wire logic [6:0] rf_addr,
   output logic [7:0] rf_rdata,
   input wire logic rf_we,
   input wire logic [7:0] rf_wdata,
   // stack
   input wire logic stack_push,
   input wire logic [12:0] stack_push_value,
   input wire logic stack_pop,
   output logic [12:0] stack_top_entry
);
   logic [7:0] mem [128];
   logic [12:0] stk [8];
   logic [6:0] wa_ff = 7'h00;
   logic [2:0] sp_ff = 3'h0;
   // known pattern so the bench can predict every read
   initial begin
      foreach (mem[i]) mem[i] = 8'(i * 37 + 5);
      foreach (stk[i]) stk[i] = 13'h1FFF;
   end
   // a pending write is passed through, so a back-to-back op reads the new value
   assign rf_rdata = (rf_we && rf_addr == wa_ff) ? rf_wdata : mem[rf_addr];
   assign stack_top_entry = stk[sp_ff - 3'h1];
   // address latched at take, since the core's address follows the next word
   always @(posedge clk) begin
      if (rf_we) mem[wa_ff] <= rf_wdata;
      if (take) wa_ff <= rf_addr;
      if (stack_push) begin
         stk[sp_ff] <= stack_push_value;
         sp_ff <= sp_ff + 3'h1;
      end else if (stack_pop) sp_ff <= sp_ff - 3'h1;
   end
endmodule : cise_partner
`default_nettype wire
